// ---- mtd_translator.sv ----
// Step translator with per-bridge fixed off-time PWM and automatic decay selection.
// Assumes all inputs are synchronous to clk_sys; analog comparators sit outside.
//
// The register addresses and strobed register access are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Reset loads home position into both windings and mixed decay on both bridges.
// - Each rising step edge advances position one increment and updates both windings.
// - Increment comes from resolution selects, sampled only at the step edge.
// - A lowered winding level uses the decay chosen by the decay-fraction input.
// - An equal or higher winding level uses slow decay.
// - Reset low holds home, turns outputs off and ignores step edges.
// - Direction level chooses forward or backward stepping through the sequence.
// - Translator drives level and current direction of both windings.
// - On phase drives a diagonal pair; comparator trip resets the PWM latch.
// - Slow decay drops only the source; fast or mixed drop source and sink.
// - Drivers stay off for the fixed off-time, then a new on phase starts.
// - Comparator is ignored for a blanking interval after every PWM state change and after re-enable; a step that reverses polarity is not blanked.
// - Active-low enable turns bridge outputs on when low, off when high.
// - Step, direction and selects keep acting whatever the enable level.
// - Over-temperature disables all outputs until the fault clears.
// - Undervoltage lockout disables drivers and returns the translator home.
// - Sleep low disables outputs; waking restarts at home.
// - Decay-fraction above high threshold is slow, below low is fast, else mixed.
// - Mixed decay runs fast for its portion, then slow for the remaining off-time.
// - Home is the 45 degree angle, equal positive current in both windings.
module mtd_translator
  import mtd_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Host control pins
  input wire logic step_in,
  input wire logic dir_in,
  input wire logic resolution_select_lo,
  input wire logic resolution_select_hi,
  input wire logic reset_n,
  input wire logic enable_n,
  input wire logic sleep_n,
  // Supervisors and comparators
  input wire logic thermal_fault,
  input wire logic undervoltage_lockout,
  input wire logic decay_fraction_level_hi,
  input wire logic decay_fraction_level_lo,
  input wire logic [1:0] trip_current,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [31:0] reg_rdata,
  // Winding levels and bridge drive
  output mtd_wind_s [1:0] winding,
  output mtd_drive_s [1:0] drive
);

  // ---------------------------------------------------------------------------
  // Table lookup
  // ---------------------------------------------------------------------------
  // Cosine of the electrical angle at a table index; sine is the same a quarter turn back.
  function automatic mtd_wind_s wind_of(input logic [4:0] idx);
    logic [3:0] k;
    logic [3:0] m;
    mtd_wind_s w;
    k = idx[3:0];
    m = (k <= MTD_MAG_LAST) ? k : 4'(MTD_HALF_CYCLE - {1'b0, k});
    w.dac = MTD_MAG_TBL[m];
    w.pol = ~((idx >= MTD_NEG_FIRST) && (idx <= MTD_NEG_LAST));
    return w;
  endfunction

  // ---------------------------------------------------------------------------
  // Conditions
  // ---------------------------------------------------------------------------
  logic home_hold;
  logic out_off;
  logic step_d_r;
  logic step_rise;
  logic [4:0] inc;
  logic [4:0] pos_r;
  logic [4:0] pos_nxt;
  mtd_wind_s [1:0] wind_r;
  mtd_wind_s [1:0] wind_nxt;
  mtd_decay_e decay_r [2];
  mtd_decay_e pfd_mode;
  logic [15:0] off_cfg_r;
  logic [15:0] blank_cfg_r;
  logic [15:0] fast_cfg_r;

  assign home_hold = ~reset_n | undervoltage_lockout | ~sleep_n;
  assign out_off = home_hold | enable_n | thermal_fault;
  assign step_rise = step_in & ~step_d_r;

  // ---------------------------------------------------------------------------
  // Step edge
  // ---------------------------------------------------------------------------
  // The edge detector keeps tracking during hold so a step held high across
  // the release of reset does not count as a fresh edge.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      step_d_r <= 1'b0;
    end else begin
      step_d_r <= step_in;
    end
  end

  // ---------------------------------------------------------------------------
  // Translator
  // ---------------------------------------------------------------------------
  always_comb begin
    case ({resolution_select_hi, resolution_select_lo})
      2'b00: inc = MTD_INC_FULL;
      2'b01: inc = MTD_INC_HALF;
      2'b10: inc = MTD_INC_QUARTER;
      default: inc = MTD_INC_EIGHTH;
    endcase
  end

  // Five-bit arithmetic wraps modulo 32 in both directions.
  assign pos_nxt = dir_in ? 5'(pos_r + inc) : 5'(pos_r - inc);
  assign wind_nxt[0] = wind_of(pos_nxt);
  assign wind_nxt[1] = wind_of(5'(pos_nxt - MTD_QUARTER_TURN));

  always_comb begin
    if (decay_fraction_level_hi) begin
      pfd_mode = MTD_DECAY_SLOW;
    end else if (decay_fraction_level_lo) begin
      pfd_mode = MTD_DECAY_FAST;
    end else begin
      pfd_mode = MTD_DECAY_MIXED;
    end
  end

  // Enable and thermal state are deliberately absent here.
  always_ff @(posedge clk_sys) begin
    if (sys_rst || home_hold) begin
      pos_r <= MTD_HOME_POS;
    end else if (step_rise) begin
      pos_r <= pos_nxt;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst || home_hold) begin
      wind_r[0] <= wind_of(MTD_HOME_POS);
      wind_r[1] <= wind_of(5'(MTD_HOME_POS - MTD_QUARTER_TURN));
    end else if (step_rise) begin
      wind_r <= wind_nxt;
    end
  end

  // ---------------------------------------------------------------------------
  // Per-bridge decay selection and PWM
  // ---------------------------------------------------------------------------
  mtd_pwm_e pwm_st_r [2];
  logic [15:0] off_cnt_r [2];
  logic [15:0] fd_cnt_r [2];
  logic [15:0] blank_cnt_r [2];
  mtd_drive_s drv_nxt [2];

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_bridge
      // A trip during the off time is ignored; only the one-shot ends it.
      logic trip_seen;
      assign trip_seen = trip_current[gi] && (blank_cnt_r[gi] == 16'h0000);

      always_ff @(posedge clk_sys) begin
        if (sys_rst || home_hold) begin
          decay_r[gi] <= MTD_DECAY_MIXED;
        end else if (step_rise) begin
          // A new mode waits for the next trip; an off time in progress keeps its own.
          if (wind_nxt[gi].dac < wind_r[gi].dac) begin
            decay_r[gi] <= pfd_mode;
          end else begin
            decay_r[gi] <= MTD_DECAY_SLOW;
          end
        end
      end

      always_ff @(posedge clk_sys) begin
        if (sys_rst || out_off) begin
          pwm_st_r[gi] <= MTD_PWM_ON;
          off_cnt_r[gi] <= 16'h0000;
          fd_cnt_r[gi] <= 16'h0000;
          // Re-enabling the outputs is a switch too, so the comparator starts blanked.
          blank_cnt_r[gi] <= MTD_BLANK_CYC;
        end else begin
          case (pwm_st_r[gi])
            MTD_PWM_ON: begin
              if (blank_cnt_r[gi] != 16'h0000) begin
                blank_cnt_r[gi] <= 16'(blank_cnt_r[gi] - 16'h0001);
              end
              if (trip_seen) begin
                off_cnt_r[gi] <= off_cfg_r;
                blank_cnt_r[gi] <= blank_cfg_r;
                case (decay_r[gi])
                  MTD_DECAY_SLOW: begin
                    pwm_st_r[gi] <= MTD_PWM_SLOW;
                    fd_cnt_r[gi] <= 16'h0000;
                  end
                  MTD_DECAY_FAST: begin
                    pwm_st_r[gi] <= MTD_PWM_FAST;
                    fd_cnt_r[gi] <= off_cfg_r;
                  end
                  default: begin
                    pwm_st_r[gi] <= MTD_PWM_FAST;
                    fd_cnt_r[gi] <= fast_cfg_r;
                  end
                endcase
              end
            end
            MTD_PWM_FAST, MTD_PWM_SLOW: begin
              if (off_cnt_r[gi] <= 16'h0001) begin
                pwm_st_r[gi] <= MTD_PWM_ON;
                blank_cnt_r[gi] <= blank_cfg_r;
              end else begin
                off_cnt_r[gi] <= 16'(off_cnt_r[gi] - 16'h0001);
                if (blank_cnt_r[gi] != 16'h0000) begin
                  blank_cnt_r[gi] <= 16'(blank_cnt_r[gi] - 16'h0001);
                end
                if (pwm_st_r[gi] == MTD_PWM_FAST) begin
                  if (fd_cnt_r[gi] <= 16'h0001) begin
                    pwm_st_r[gi] <= MTD_PWM_SLOW;
                    blank_cnt_r[gi] <= blank_cfg_r;
                  end else begin
                    fd_cnt_r[gi] <= 16'(fd_cnt_r[gi] - 16'h0001);
                  end
                end
              end
            end
            default: begin
              pwm_st_r[gi] <= MTD_PWM_ON;
            end
          endcase
        end
      end

      // Positive current flows source a to sink b; slow decay recirculates through the sink.
      always_comb begin
        drv_nxt[gi] = MTD_DRIVE_OFF;
        if (!out_off) begin
          case (pwm_st_r[gi])
            MTD_PWM_ON: begin
              drv_nxt[gi].src_a = wind_r[gi].pol;
              drv_nxt[gi].snk_b = wind_r[gi].pol;
              drv_nxt[gi].src_b = ~wind_r[gi].pol;
              drv_nxt[gi].snk_a = ~wind_r[gi].pol;
            end
            MTD_PWM_SLOW: begin
              drv_nxt[gi].snk_b = wind_r[gi].pol;
              drv_nxt[gi].snk_a = ~wind_r[gi].pol;
            end
            default: begin
              drv_nxt[gi] = MTD_DRIVE_OFF;
            end
          endcase
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  // Every leg is registered so all four change on one edge and none glitches.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      drive <= {MTD_DRIVE_OFF, MTD_DRIVE_OFF};
    end else begin
      drive <= {drv_nxt[1], drv_nxt[0]};
    end
  end

  // Winding outputs lag the translator by one cycle so they come from a flop.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      winding[0] <= wind_of(MTD_HOME_POS);
      winding[1] <= wind_of(5'(MTD_HOME_POS - MTD_QUARTER_TURN));
    end else begin
      winding <= wind_r;
    end
  end

  // ---------------------------------------------------------------------------
  // Register port
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      off_cfg_r <= MTD_OFF_CYC;
      blank_cfg_r <= MTD_BLANK_CYC;
      fast_cfg_r <= MTD_FAST_CYC;
    end else if (reg_we) begin
      case (reg_addr)
        MTD_REG_OFF_TIME: off_cfg_r <= reg_wdata[15:0];
        MTD_REG_BLANK_TIME: blank_cfg_r <= reg_wdata[15:0];
        MTD_REG_FAST_TIME: fast_cfg_r <= reg_wdata[15:0];
        default: begin
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Status word
  // ---------------------------------------------------------------------------
  // A read shows live levels; nothing here latches, so a short fault can be missed.
  logic [31:0] status;
  always_comb begin
    status = 32'h0000_0000;
    status[MTD_ST_POS_LSB +: 5] = pos_r;
    status[MTD_ST_DECAY_A_LSB +: 2] = decay_r[0];
    status[MTD_ST_DECAY_B_LSB +: 2] = decay_r[1];
    status[MTD_ST_POL_A] = wind_r[0].pol;
    status[MTD_ST_POL_B] = wind_r[1].pol;
    status[MTD_ST_OUT_OFF] = out_off;
    status[MTD_ST_THERMAL] = thermal_fault;
    status[MTD_ST_HOME_HOLD] = home_hold;
  end

  // Unmapped addresses and idle cycles read as zero.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_re) begin
      case (reg_addr)
        MTD_REG_OFF_TIME: reg_rdata <= {16'h0000, off_cfg_r};
        MTD_REG_BLANK_TIME: reg_rdata <= {16'h0000, blank_cfg_r};
        MTD_REG_FAST_TIME: reg_rdata <= {16'h0000, fast_cfg_r};
        MTD_REG_STATUS: reg_rdata <= status;
        default: reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

endmodule // mtd_translator

`default_nettype wire

// ---- mtd_pkg.sv ----
// Constants, types and register map for the microstep translator and decay control.
// Assumes a single 100 MHz system clock and a plain register port on the top module.
`default_nettype none

package mtd_pkg;

  // ---------------------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------------------
  localparam int MTD_CLK_PERIOD_NS = 10;
  localparam int MTD_OFF_TIME_NS = 38000;
  localparam int MTD_BLANK_TIME_NS = 950;
  localparam int MTD_FAST_TIME_NS = 9500;
  localparam logic [15:0] MTD_OFF_CYC = 16'(MTD_OFF_TIME_NS / MTD_CLK_PERIOD_NS);
  localparam logic [15:0] MTD_BLANK_CYC =
    16'((MTD_BLANK_TIME_NS + MTD_CLK_PERIOD_NS - 1) / MTD_CLK_PERIOD_NS);
  localparam logic [15:0] MTD_FAST_CYC = 16'(MTD_FAST_TIME_NS / MTD_CLK_PERIOD_NS);

  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam logic [7:0] MTD_REG_OFF_TIME = 8'h00;
  localparam logic [7:0] MTD_REG_BLANK_TIME = 8'h04;
  localparam logic [7:0] MTD_REG_FAST_TIME = 8'h08;
  localparam logic [7:0] MTD_REG_STATUS = 8'h0C;

  // Status field positions.
  localparam int MTD_ST_POS_LSB = 0;
  localparam int MTD_ST_DECAY_A_LSB = 5;
  localparam int MTD_ST_DECAY_B_LSB = 7;
  localparam int MTD_ST_POL_A = 9;
  localparam int MTD_ST_POL_B = 10;
  localparam int MTD_ST_OUT_OFF = 11;
  localparam int MTD_ST_THERMAL = 12;
  localparam int MTD_ST_HOME_HOLD = 13;

  // ---------------------------------------------------------------------------
  // Translator
  // ---------------------------------------------------------------------------
  localparam logic [4:0] MTD_HOME_POS = 5'h04;
  localparam logic [4:0] MTD_QUARTER_TURN = 5'h08;
  localparam logic [4:0] MTD_INC_FULL = 5'h08;
  localparam logic [4:0] MTD_INC_HALF = 5'h04;
  localparam logic [4:0] MTD_INC_QUARTER = 5'h02;
  localparam logic [4:0] MTD_INC_EIGHTH = 5'h01;
  localparam logic [3:0] MTD_MAG_LAST = 4'h8;
  localparam logic [4:0] MTD_NEG_FIRST = 5'h09;
  localparam logic [4:0] MTD_NEG_LAST = 5'h17;
  localparam logic [4:0] MTD_HALF_CYCLE = 5'h10;

  // Winding magnitude per eighth-step index 0..8, full scale at index 0.
  localparam logic [8:0][7:0] MTD_MAG_TBL = {
    8'h00, 8'h32, 8'h62, 8'h8E, 8'hB4, 8'hD4, 8'hEC, 8'hFA, 8'hFF
  };

  typedef enum logic [1:0] {
    MTD_DECAY_SLOW = 2'h0,
    MTD_DECAY_FAST = 2'h1,
    MTD_DECAY_MIXED = 2'h2
  } mtd_decay_e;

  typedef enum logic [2:0] {
    MTD_PWM_ON = 3'b001,
    MTD_PWM_FAST = 3'b010,
    MTD_PWM_SLOW = 3'b100
  } mtd_pwm_e;

  // Level and current polarity of one winding; pol high is positive current.
  typedef struct packed {
    logic pol;
    logic [7:0] dac;
  } mtd_wind_s;

  // Bridge legs: source and sink of leg a and leg b.
  typedef struct packed {
    logic src_a;
    logic snk_a;
    logic src_b;
    logic snk_b;
  } mtd_drive_s;

  localparam mtd_drive_s MTD_DRIVE_OFF = '{src_a: 1'b0, snk_a: 1'b0, src_b: 1'b0, snk_b: 1'b0};

endpackage : mtd_pkg

`default_nettype wire

// ---- mtd_translator_monitor.sv ----
// Checker of the translator pins: holds, output gating and step timing.
// Assumes it is bound into mtd_translator and sees only its ports.
`timescale 1ns/1ps
`default_nettype none

module mtd_translator_chk
  import mtd_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Control pins
  input wire logic step_in,
  input wire logic reset_n,
  input wire logic enable_n,
  input wire logic sleep_n,
  input wire logic thermal_fault,
  input wire logic undervoltage_lockout,
  // Outputs
  input wire mtd_wind_s [1:0] winding,
  input wire mtd_drive_s [1:0] drive
);
  localparam mtd_wind_s HOME = '{pol: 1'b1, dac: 8'hB4};
  wire logic hold = !reset_n || !sleep_n || undervoltage_lockout;
  wire logic at_home = winding[0] == HOME && winding[1] == HOME;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  property p_home_rst; $fell(sys_rst) |-> at_home; endproperty
  a_home_rst: assert property (p_home_rst) else $error("not home after reset");
  property p_rst_drv; !reset_n |=> drive == '0; endproperty
  a_rst_drv: assert property (p_rst_drv) else $error("drive on in reset");
  property p_rst_home; !reset_n ##1 !reset_n |=> at_home; endproperty
  a_rst_home: assert property (p_rst_home) else $error("not home in reset");
  property p_en; enable_n |=> drive == '0; endproperty
  a_en: assert property (p_en) else $error("drive on while disabled");
  property p_therm; thermal_fault |=> drive == '0; endproperty
  a_therm: assert property (p_therm) else $error("drive on while hot");
  property p_uv; undervoltage_lockout ##1 undervoltage_lockout |=> at_home && drive == '0; endproperty
  a_uv: assert property (p_uv) else $error("lockout not held");
  property p_sleep; !sleep_n ##1 !sleep_n |=> at_home && drive == '0; endproperty
  a_sleep: assert property (p_sleep) else $error("sleep not held");
  property p_diag;
    (drive[0].src_a |-> drive[0].snk_b && !drive[0].snk_a) and
    (drive[0].src_b |-> drive[0].snk_a && !drive[0].snk_b) and
    (drive[1].src_a |-> drive[1].snk_b && !drive[1].snk_a) and
    (drive[1].src_b |-> drive[1].snk_a && !drive[1].snk_b);
  endproperty
  a_diag: assert property (p_diag) else $error("source without diagonal sink");
  property p_step;
    $changed(winding) |-> ($past(step_in, 2) && !$past(step_in, 3)) || $past(hold, 2);
  endproperty
  a_step: assert property (p_step) else $error("winding moved without step");
endmodule // mtd_translator_chk

bind mtd_translator mtd_translator_chk u_chk (.clk_sys(clk_sys), .sys_rst(sys_rst),
  .step_in(step_in), .reset_n(reset_n), .enable_n(enable_n), .sleep_n(sleep_n),
  .thermal_fault(thermal_fault), .undervoltage_lockout(undervoltage_lockout),
  .winding(winding), .drive(drive));

`default_nettype wire

// ---- mtd_host_model.sv ----
// Host that issues step pulses and holds direction and select levels.
// Assumes the bench commands it with go pulses and a width of at least 1.
`timescale 1ns/1ps
`default_nettype none

module mtd_host_model
  import mtd_pkg::*;
(
  // Clock, reset and commands
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic go,
  input wire logic [3:0] width,
  input wire logic dir,
  input wire logic [1:0] sel,
  // Pins
  output logic busy,
  output logic step_in,
  output logic dir_in,
  output logic resolution_select_lo,
  output logic resolution_select_hi
);
  logic [4:0] left_r;
  // Levels follow at every edge, so a select change can land well before its step.
  always_ff @(posedge clk_sys) begin
    dir_in <= dir;
    resolution_select_lo <= sel[0];
    resolution_select_hi <= sel[1];
  end
  // Step is high for width cycles, then low, so a slow host is as easy as a fast one.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      left_r <= 5'h0;
      step_in <= 1'b0;
      busy <= 1'b0;
    end else if (go && !busy) begin
      left_r <= {width, 1'b0} - 5'd1;
      step_in <= 1'b1;
      busy <= 1'b1;
    end else if (left_r != 5'h0) begin
      left_r <= left_r - 5'd1;
      step_in <= (left_r - 5'd1) >= {1'b0, width};
      busy <= left_r != 5'd1;
    end
  end
endmodule // mtd_host_model

`default_nettype wire

// ---- mtd_translator_tb_top.sv ----
// Self-checking bench for the step translator and its PWM bridges.
// Assumes the host model drives the step, direction and select pins.
`timescale 1ns/1ps
`default_nettype none

module mtd_translator_tb_top
  import mtd_pkg::*;
;
  logic clk_sys = 1'b0, sys_rst = 1'b1, go = 1'b0, dir = 1'b1, busy;
  logic reset_n = 1'b1, enable_n = 1'b0, sleep_n = 1'b1, therm = 1'b0, uv = 1'b0;
  logic pfd_hi = 1'b0, pfd_lo = 1'b0, we = 1'b0, re = 1'b0, step_in, dir_in, ms_lo, ms_hi;
  logic [1:0] sel = 2'h0, trip = 2'h0;
  logic [3:0] width = 4'h1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0, reg_rdata, rd;
  mtd_wind_s [1:0] winding;
  mtd_drive_s [1:0] drive;
  int num_errors = 0, checked = 0, cycles = 0;

  mtd_host_model u_host (.clk_sys(clk_sys), .sys_rst(sys_rst), .go(go), .width(width),
    .dir(dir), .sel(sel), .busy(busy), .step_in(step_in), .dir_in(dir_in),
    .resolution_select_lo(ms_lo), .resolution_select_hi(ms_hi));
  mtd_translator uut (.clk_sys(clk_sys), .sys_rst(sys_rst), .step_in(step_in),
    .dir_in(dir_in), .resolution_select_lo(ms_lo), .resolution_select_hi(ms_hi),
    .reset_n(reset_n), .enable_n(enable_n), .sleep_n(sleep_n), .thermal_fault(therm),
    .undervoltage_lockout(uv), .decay_fraction_level_hi(pfd_hi),
    .decay_fraction_level_lo(pfd_lo), .trip_current(trip), .reg_addr(addr),
    .reg_wdata(wdata), .reg_we(we), .reg_re(re), .reg_rdata(reg_rdata),
    .winding(winding), .drive(drive));

  initial begin
    forever #5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      $display("BAD %0t timeout", $time);
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  // Expected level from the index: cosine for winding A, B is the same a quarter behind.
  task automatic chkw(input mtd_wind_s got, input logic [4:0] p);
    logic [4:0] d;
    mtd_wind_s e;
    d = (p <= 5'd16) ? p : 5'd0 - p;
    e.dac = MTD_MAG_TBL[(d <= 5'd8) ? d : 5'd16 - d];
    e.pol = !(p >= 5'd9 && p <= 5'd23);
    chk32(32'(got), 32'(e), "winding");
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge clk_sys);
    we <= 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a);
    @(posedge clk_sys);
    addr <= a;
    re <= 1'b1;
    @(posedge clk_sys);
    re <= 1'b0;
    #1 rd = reg_rdata;
  endtask

  task automatic do_step(input logic d, input logic [1:0] s);
    int n;
    dir <= d;
    sel <= s;
    @(posedge clk_sys);
    go <= 1'b1;
    @(posedge clk_sys);
    go <= 1'b0;
    #1 n = 0;
    while (busy !== 1'b0 && n < 100) begin
      @(negedge clk_sys);
      n++;
    end
    repeat (3) @(posedge clk_sys);
    #1;
  endtask

  task automatic check_pos(input logic [4:0] p, input logic [1:0] da, input logic [1:0] db);
    chkw(winding[0], p);
    chkw(winding[1], p - 5'd8);
    reg_rd(MTD_REG_STATUS);
    chk32(rd & 32'h1FF, 32'({db, da, p}), "status");
  endtask

  task automatic t_reset();
    check_pos(MTD_HOME_POS, 2'h2, 2'h2);
    reg_rd(MTD_REG_OFF_TIME);
    chk32(rd, 32'd3800, "off default");
    reg_rd(MTD_REG_FAST_TIME);
    chk32(rd, 32'd950, "fast default");
    reg_rd(MTD_REG_BLANK_TIME);
    chk32(rd, 32'd95, "blank default");
    reg_rd(8'h10);
    chk32(rd, 32'h0, "unmapped");
    $display("test reset done");
  endtask

  task automatic t_full();
    for (int i = 1; i <= 4; i++) begin
      do_step(1'b1, 2'h0);
      check_pos(5'(4 + 8 * i), 2'h0, 2'h0);
    end
    $display("test full step done");
  endtask

  task automatic t_micro();
    pfd_lo <= 1'b1;
    do_step(1'b0, 2'h3);
    check_pos(5'd3, 2'h0, 2'h1);
    sel <= 2'h1;
    repeat (4) @(posedge clk_sys);
    check_pos(5'd3, 2'h0, 2'h1);
    pfd_lo <= 1'b0;
    width <= 4'h5;
    do_step(1'b0, 2'h1);
    check_pos(5'd31, 2'h0, 2'h2);
    pfd_hi <= 1'b1;
    width <= 4'h1;
    do_step(1'b1, 2'h3);
    check_pos(5'd0, 2'h0, 2'h0);
    pfd_hi <= 1'b0;
    $display("test microstep done");
  endtask

  task automatic t_hold();
    for (int k = 0; k < 3; k++) begin
      do_step(1'b1, 2'h0);
      reset_n <= (k != 0);
      sleep_n <= (k != 1);
      uv <= (k == 2);
      do_step(1'b1, 2'h0);
      check_pos(MTD_HOME_POS, 2'h2, 2'h2);
      chk32(32'(drive), 32'h0, "held drive");
      reset_n <= 1'b1;
      sleep_n <= 1'b1;
      uv <= 1'b0;
    end
    $display("test hold done");
  endtask

  task automatic t_gate();
    enable_n <= 1'b1;
    do_step(1'b1, 2'h0);
    check_pos(5'd12, 2'h0, 2'h0);
    chk32(32'(drive), 32'h0, "disabled drive");
    enable_n <= 1'b0;
    therm <= 1'b1;
    repeat (3) @(posedge clk_sys);
    #1 chk32(32'(drive), 32'h0, "hot drive");
    therm <= 1'b0;
    reset_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    reset_n <= 1'b1;
    $display("test gating done");
  endtask

  task automatic t_pwm();
    int n;
    reg_wr(MTD_REG_OFF_TIME, 32'h0001_0014);
    reg_wr(MTD_REG_BLANK_TIME, 32'd3);
    reg_wr(MTD_REG_FAST_TIME, 32'd5);
    reg_rd(MTD_REG_OFF_TIME);
    chk32(rd, 32'd20, "off written");
    repeat (110) @(posedge clk_sys);
    #1 chk32(32'(drive), 32'h99, "on phase");
    trip <= 2'h1;
    @(posedge clk_sys);
    trip <= 2'h0;
    repeat (3) @(posedge clk_sys);
    #1 chk32(32'(drive), 32'h90, "fast part");
    repeat (8) @(posedge clk_sys);
    #1 chk32(32'(drive), 32'h91, "slow part");
    n = 0;
    while (drive !== 8'h99 && n < 40) begin
      @(negedge clk_sys);
      n++;
    end
    chk32(32'(n > 3 && n < 20), 32'h1, "off time");
    trip <= 2'h1;
    @(negedge clk_sys);
    trip <= 2'h0;
    repeat (3) @(posedge clk_sys);
    #1 chk32(32'(drive), 32'h99, "blanked trip");
    pfd_lo <= 1'b1;
    do_step(1'b1, 2'h3);
    check_pos(5'd5, 2'h1, 2'h0);
    trip <= 2'h3;
    @(posedge clk_sys);
    trip <= 2'h0;
    repeat (3) @(posedge clk_sys);
    #1 chk32(32'(drive), 32'h10, "fast and slow");
    repeat (8) @(posedge clk_sys);
    #1 chk32(32'(drive), 32'h10, "whole fast off");
    pfd_lo <= 1'b0;
    $display("test pwm done");
  endtask

  initial begin
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    t_reset();
    t_full();
    t_micro();
    t_hold();
    t_gate();
    t_pwm();
    report_and_stop();
  end
endmodule // mtd_translator_tb_top

`default_nettype wire
